// File: rtl/iep_pkg.sv
package iep_pkg;

  // ****************************************
  // special-function addresses
  // ****************************************
  localparam logic [7:0] IEP_ADDR_ENABLE = 8'ha8;   // interrupt_enable_mask
  localparam logic [7:0] IEP_ADDR_SECOND = 8'ha9;   // secondary_enable_priority
  localparam logic [7:0] IEP_ADDR_PRIO = 8'hb8;     // interrupt_priority_select

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] IEP_RST_ENABLE = 8'h00;
  localparam logic [7:0] IEP_RST_SECOND = 8'ha0;
  localparam logic [7:0] IEP_RST_PRIO = 8'h00;

  // ****************************************
  // implemented bit masks
  // ****************************************
  localparam logic [7:0] IEP_MASK_PRIO = 8'h7f;     // bit 7 not implemented
  localparam logic [7:0] IEP_MASK_SECOND = 8'hf7;   // bit 3 held at zero

  // ****************************************
  // enable register field positions
  // ****************************************
  localparam int IEP_EN_GLOBAL = 7;
  localparam int IEP_EN_CONV = 6;
  localparam int IEP_EN_TIMER2 = 5;
  localparam int IEP_EN_UART = 4;
  localparam int IEP_EN_TIMER1 = 3;
  localparam int IEP_EN_EXT1 = 2;
  localparam int IEP_EN_TIMER0 = 1;
  localparam int IEP_EN_EXT0 = 0;

  // ****************************************
  // secondary register field positions
  // ****************************************
  localparam int IEP_SEC_PRIO_INTERVAL = 6;
  localparam int IEP_SEC_PRIO_SUPPLY = 5;
  localparam int IEP_SEC_EN_INTERVAL = 2;
  localparam int IEP_SEC_EN_SUPPLY = 1;

  // ****************************************
  // sources, index equals polling order
  // ****************************************
  localparam int IEP_NSRC = 9;
  localparam int IEP_SRC_SUPPLY = 0;
  localparam int IEP_SRC_EXT0 = 1;
  localparam int IEP_SRC_CONV = 2;
  localparam int IEP_SRC_TIMER0 = 3;
  localparam int IEP_SRC_EXT1 = 4;
  localparam int IEP_SRC_TIMER1 = 5;
  localparam int IEP_SRC_UART = 6;
  localparam int IEP_SRC_TIMER2 = 7;
  localparam int IEP_SRC_INTERVAL = 8;

  // ****************************************
  // vector table: base plus step per source
  // ****************************************
  localparam logic [15:0] IEP_VEC_BASE = 16'h0003;
  localparam logic [15:0] IEP_VEC_STEP = 16'h0008;

endpackage

// File: rtl/iep_pick.sv
`timescale 1ns/1ps

// ****************************************
// fixed-order picker, index 0 wins
// ****************************************
module iep_pick
  import iep_pkg::*;
(
  input wire logic [IEP_NSRC-1:0] req, // candidate requests
  output logic found,                  // any request present
  output logic [3:0] idx               // index of the winner
);

  logic [IEP_NSRC:0] lower_any;
  logic [IEP_NSRC-1:0] win;

  assign lower_any[0] = 1'b0;

  // one-hot winner through a prefix chain
  genvar g;
  generate
    for (g = 0; g < IEP_NSRC; g = g + 1) begin : g_chain
      assign win[g] = req[g] & ~lower_any[g];
      assign lower_any[g+1] = lower_any[g] | req[g];
    end
  endgenerate

  assign found = lower_any[IEP_NSRC];

  // encode the one-hot winner
  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < IEP_NSRC; i++) begin
      if (win[i]) begin
        idx = 4'(i);
      end
    end
  end

endmodule // iep_pick

// File: rtl/iep_core.sv
`timescale 1ns/1ps

// Behaviour
// - nine sources are handled, each set to one of two priority levels.
// - enable bit 7 is a global gate; cleared, no source interrupts.
// - enable bit 6 gates the converter interrupt.
// - enable bit 5 gates the timer two interrupt.
// - enable bit 4 gates the serial port interrupt.
// - enable bit 3 gates the timer one interrupt.
// - enable bit 2 gates external pin one.
// - enable bit 1 gates the timer zero interrupt.
// - enable bit 0 gates external pin zero.
// - the enable register sits at a8 and resets to 00, all disabled.
// - the priority register sits at b8, resets to 00 and takes single-bit writes.
// - a high-level request may preempt a low-level service routine.
// - a service in progress is never preempted at its own level.
// - equal-level requests resolve in fixed polling order, supply monitor first.
// - on entry the core pushes the counter and jumps to the source vector given here.
module iep_core
  import iep_pkg::*;
(
  input wire logic clk,                          // core clock
  input wire logic reset,                        // synchronous, active high
  input wire logic [7:0] sfr_addr,               // byte access address
  input wire logic sfr_wr,                       // byte write strobe
  input wire logic sfr_rd,                       // byte read strobe
  input wire logic [7:0] sfr_wdata,              // byte write data
  output logic [7:0] sfr_rdata,                  // byte read data
  input wire logic [7:0] bit_addr,               // bit access address
  input wire logic bit_wr,                       // bit write strobe
  input wire logic bit_rd,                       // bit read strobe
  input wire logic bit_wdata,                    // bit write value
  output logic bit_rdata,                        // bit read value
  input wire logic [IEP_NSRC-1:0] irq_pending,   // held source flags
  output logic [IEP_NSRC-1:0] irq_taken,         // one-hot pulse, source entered
  output logic core_irq_valid,                   // request to the core
  output logic [15:0] core_irq_vector,           // vector address for entry
  output logic core_irq_high,                    // level of the request
  input wire logic core_irq_ack,                 // core takes the request
  input wire logic core_reti,                    // core leaves a routine
  output logic [1:0] in_service                  // bit1 high, bit0 low level busy
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] enable_r;
  logic [7:0] second_r;
  logic [7:0] prio_r;
  logic [7:0] sfr_rdata_r;
  logic bit_rdata_r;
  logic valid_r;
  logic [3:0] src_r;
  logic [15:0] vector_r;
  logic high_r;
  logic [IEP_NSRC-1:0] taken_r;
  logic active_hi_r;
  logic active_lo_r;

  // ****************************************
  // per-source enable and level maps
  // ****************************************
  logic [IEP_NSRC-1:0] src_en;
  logic [IEP_NSRC-1:0] src_hi;
  logic [IEP_NSRC-1:0] gated;
  logic [IEP_NSRC-1:0] req_hi;
  logic [IEP_NSRC-1:0] req_lo;

  // individual enables placed in polling order
  always_comb begin
    src_en = '0;
    src_en[IEP_SRC_SUPPLY] = second_r[IEP_SEC_EN_SUPPLY];
    src_en[IEP_SRC_EXT0] = enable_r[IEP_EN_EXT0];
    src_en[IEP_SRC_CONV] = enable_r[IEP_EN_CONV];
    src_en[IEP_SRC_TIMER0] = enable_r[IEP_EN_TIMER0];
    src_en[IEP_SRC_EXT1] = enable_r[IEP_EN_EXT1];
    src_en[IEP_SRC_TIMER1] = enable_r[IEP_EN_TIMER1];
    src_en[IEP_SRC_UART] = enable_r[IEP_EN_UART];
    src_en[IEP_SRC_TIMER2] = enable_r[IEP_EN_TIMER2];
    src_en[IEP_SRC_INTERVAL] = second_r[IEP_SEC_EN_INTERVAL];
  end

  // priority bits placed in polling order
  always_comb begin
    src_hi = '0;
    src_hi[IEP_SRC_SUPPLY] = second_r[IEP_SEC_PRIO_SUPPLY];
    src_hi[IEP_SRC_EXT0] = prio_r[IEP_EN_EXT0];
    src_hi[IEP_SRC_CONV] = prio_r[IEP_EN_CONV];
    src_hi[IEP_SRC_TIMER0] = prio_r[IEP_EN_TIMER0];
    src_hi[IEP_SRC_EXT1] = prio_r[IEP_EN_EXT1];
    src_hi[IEP_SRC_TIMER1] = prio_r[IEP_EN_TIMER1];
    src_hi[IEP_SRC_UART] = prio_r[IEP_EN_UART];
    src_hi[IEP_SRC_TIMER2] = prio_r[IEP_EN_TIMER2];
    src_hi[IEP_SRC_INTERVAL] = second_r[IEP_SEC_PRIO_INTERVAL];
  end

  // pending flags pass only under both enables
  assign gated = irq_pending & src_en & {IEP_NSRC{enable_r[IEP_EN_GLOBAL]}};
  assign req_hi = gated & src_hi;
  assign req_lo = gated & ~src_hi;

  // ****************************************
  // arbitration
  // ****************************************
  logic hi_found;
  logic lo_found;
  logic [3:0] hi_idx;
  logic [3:0] lo_idx;

  // polling order within each level
  iep_pick u_pick_hi (
    .req(req_hi),
    .found(hi_found),
    .idx(hi_idx)
  );

  iep_pick u_pick_lo (
    .req(req_lo),
    .found(lo_found),
    .idx(lo_idx)
  );

  logic cand_hi;
  logic cand_lo;
  logic cand;
  logic [3:0] cand_idx;

  // high level blocked only by a high service
  assign cand_hi = hi_found & ~active_hi_r;

  // low level blocked by any service or any high request
  assign cand_lo = ~hi_found & lo_found & ~active_hi_r & ~active_lo_r;

  // merged candidate, high level first
  assign cand = cand_hi | cand_lo;
  assign cand_idx = cand_hi ? hi_idx : lo_idx;

  // ****************************************
  // request to the core
  // ****************************************
  logic entry;

  // an acknowledge counts only while a request stands
  assign entry = core_irq_ack & valid_r;

  // withdrawn for one cycle after an entry, so the flag can drop
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= cand & ~entry;
    end
  end

  // winner index and level, kept for the entry pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      src_r <= 4'h0;
      high_r <= 1'b0;
    end else begin
      src_r <= cand_idx;
      high_r <= cand_hi;
    end
  end

  // vector of the winner, base plus step per index
  always_ff @(posedge clk) begin
    if (reset) begin
      vector_r <= 16'h0000;
    end else begin
      vector_r <= IEP_VEC_BASE + 16'(IEP_VEC_STEP * cand_idx);
    end
  end

  // one-hot taken pulse so the source can drop its flag
  always_ff @(posedge clk) begin
    if (reset) begin
      taken_r <= '0;
    end else begin
      taken_r <= '0;
      if (entry) begin
        taken_r[src_r] <= 1'b1;
      end
    end
  end

  // ****************************************
  // in-service tracking
  // ****************************************
  // an entry in the cycle of a return wins over the clear
  // high busy: set on a high entry, cleared by a return
  always_ff @(posedge clk) begin
    if (reset) begin
      active_hi_r <= 1'b0;
    end else if (entry && high_r) begin
      active_hi_r <= 1'b1;
    end else if (core_reti) begin
      active_hi_r <= 1'b0;
    end
  end

  // low busy: a return clears it only with no high routine busy
  always_ff @(posedge clk) begin
    if (reset) begin
      active_lo_r <= 1'b0;
    end else if (entry && !high_r) begin
      active_lo_r <= 1'b1;
    end else if (core_reti && !active_hi_r) begin
      active_lo_r <= 1'b0;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // bit addresses b8 to bf land on the priority register
  logic bit_hits_prio;
  assign bit_hits_prio = (bit_addr[7:3] == IEP_ADDR_PRIO[7:3]);

  // enable register, byte access only
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_r <= IEP_RST_ENABLE;
    end else if (sfr_wr && sfr_addr == IEP_ADDR_ENABLE) begin
      enable_r <= sfr_wdata;
    end
  end

  // secondary register, bit 3 forced low
  always_ff @(posedge clk) begin
    if (reset) begin
      second_r <= IEP_RST_SECOND;
    end else if (sfr_wr && sfr_addr == IEP_ADDR_SECOND) begin
      second_r <= sfr_wdata & IEP_MASK_SECOND;
    end
  end

  // priority register, byte write then bit write
  always_ff @(posedge clk) begin
    if (reset) begin
      prio_r <= IEP_RST_PRIO;
    end else begin
      if (sfr_wr && sfr_addr == IEP_ADDR_PRIO) begin
        prio_r <= sfr_wdata & IEP_MASK_PRIO;
      end
      // same-cycle bit write wins for its bit
      if (bit_wr && bit_hits_prio && bit_addr[2:0] != 3'h7) begin
        prio_r[bit_addr[2:0]] <= bit_wdata;
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  logic [7:0] sfr_rmux;

  // byte read select, unmapped addresses give zero
  always_comb begin
    unique case (sfr_addr)
      IEP_ADDR_ENABLE: sfr_rmux = enable_r;
      IEP_ADDR_SECOND: sfr_rmux = second_r;
      IEP_ADDR_PRIO: sfr_rmux = prio_r;
      default: sfr_rmux = 8'h00;
    endcase
  end

  // byte read data, held between read strobes
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= sfr_rmux;
    end
  end

  // bit reads of the priority register, others zero
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_rdata_r <= 1'b0;
    end else if (bit_rd) begin
      bit_rdata_r <= bit_hits_prio & prio_r[bit_addr[2:0]];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // register bus answers
  assign sfr_rdata = sfr_rdata_r;
  assign bit_rdata = bit_rdata_r;

  // core link and entry pulse
  assign irq_taken = taken_r;
  assign core_irq_valid = valid_r;
  assign core_irq_vector = vector_r;
  assign core_irq_high = high_r;

  // busy levels
  assign in_service = {active_hi_r, active_lo_r};

endmodule // iep_core

// File: test/iep_core_properties.sv
`timescale 1ns/1ps
// ****************************************
// interrupt entry checks
// ****************************************
module iep_core_properties
  import iep_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire logic [7:0] sfr_addr, // byte address
  input wire logic sfr_wr, // byte write
  input wire logic sfr_rd, // byte read
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic [7:0] bit_addr, // bit address
  input wire logic bit_rd, // bit read
  input wire logic bit_rdata, // bit data
  input wire logic [IEP_NSRC-1:0] irq_pending, // source flags
  input wire logic [IEP_NSRC-1:0] irq_taken, // entry pulse
  input wire logic core_irq_valid, // request
  input wire logic [15:0] core_irq_vector, // vector
  input wire logic core_irq_high, // level
  input wire logic core_irq_ack, // core ack
  input wire logic core_reti, // return
  input wire logic [1:0] in_service // busy levels
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // entry handshake and register write-read steps
  sequence take_s;
    core_irq_valid && core_irq_ack;
  endsequence
  sequence wr_rd_s;
    sfr_wr && sfr_addr == IEP_ADDR_ENABLE ##1 !sfr_wr ##1
      sfr_rd && !sfr_wr && sfr_addr == IEP_ADDR_ENABLE;
  endsequence
  enable_read_a: assert property (wr_rd_s |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("enable read back wrong");
  unmapped_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h00 |=>
    sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  bit_outside_a: assert property (bit_rd && bit_addr == 8'h00 |=> !bit_rdata)
    else $error("bit read outside not zero");
  gated_req_a: assert property (core_irq_valid |-> $past(|irq_pending))
    else $error("request without flag");
  vector_form_a: assert property (core_irq_valid |->
    core_irq_vector[2:0] == 3'h3 && core_irq_vector < 16'h004b)
    else $error("vector out of table");
  entry_pulse_a: assert property (take_s |=>
    $onehot(irq_taken) && !core_irq_valid ##1 irq_taken == '0)
    else $error("entry pulse wrong");
  low_busy_a: assert property ((take_s and !core_irq_high) |=> in_service[0])
    else $error("low busy not set");
  high_busy_a: assert property ((take_s and core_irq_high) |=> in_service[1])
    else $error("high busy not set");
  low_blocked_a: assert property (in_service != 2'h0 |->
    !(core_irq_valid && !core_irq_high))
    else $error("low request while busy");
  high_blocked_a: assert property (in_service[1] |-> !core_irq_valid)
    else $error("request while high busy");
  reti_clear_a: assert property (core_reti && !core_irq_ack && in_service == 2'h1 |=>
    in_service == 2'h0)
    else $error("return did not clear");
endmodule // iep_core_properties

bind iep_core iep_core_properties chk_i (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .bit_addr, .bit_rd, .bit_rdata, .irq_pending, .irq_taken, .core_irq_valid,
  .core_irq_vector, .core_irq_high, .core_irq_ack, .core_reti, .in_service);

// File: test/iep_core_partner.sv
`timescale 1ns/1ps
// ****************************************
// core and source stand-in
// ****************************************
module iep_core_partner
  import iep_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset, // sync reset
  input wire logic [IEP_NSRC-1:0] raise, // source events
  input wire logic [IEP_NSRC-1:0] irq_taken, // entry taken
  input wire logic core_irq_valid, // request seen
  input wire logic ack_on, // core willing
  input wire logic [3:0] ack_wait, // delay before ack
  output logic [IEP_NSRC-1:0] irq_pending, // held flags
  output logic core_irq_ack // entry pulse
);
  logic [3:0] wait_r;
  // flags held until entry, one-cycle ack after a set delay
  always @(negedge clk) begin
    if (reset) begin
      irq_pending <= '0;
      core_irq_ack <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      irq_pending <= (irq_pending & ~irq_taken) | raise;
      core_irq_ack <= core_irq_valid && ack_on && !core_irq_ack && wait_r == ack_wait;
      if (!core_irq_valid || !ack_on || core_irq_ack) wait_r <= 4'h0;
      else if (wait_r != ack_wait) wait_r <= wait_r + 4'h1;
    end
  end
endmodule // iep_core_partner

// File: test/interrupt_enable_priority_tb.sv
`timescale 1ns/1ps
// ****************************************
// bench for interrupt enable and priority
// ****************************************
module interrupt_enable_priority_tb;
  import iep_pkg::*;
  logic clk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_rd = 1'b0;
  logic bit_wdata = 1'b0, core_reti = 1'b0, ack_on = 1'b1, bit_rdata, core_irq_valid;
  logic core_irq_high, core_irq_ack;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata;
  logic [3:0] ack_wait = 4'h0;
  logic [IEP_NSRC-1:0] raise = '0, irq_pending, irq_taken;
  logic [15:0] core_irq_vector;
  logic [1:0] in_service;
  int n_mismatch = 0, checked = 0;
  // 50 ns clock
  always #25 clk = ~clk;
  // block and its far side
  iep_core uut (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_addr,
    .bit_wr, .bit_rd, .bit_wdata, .bit_rdata, .irq_pending, .irq_taken, .core_irq_valid,
    .core_irq_vector, .core_irq_high, .core_irq_ack, .core_reti, .in_service);
  iep_core_partner far (.clk, .reset, .raise, .irq_taken, .core_irq_valid, .ack_on, .ack_wait,
    .irq_pending, .core_irq_ack);
  // ****************************************
  // helpers
  // ****************************************
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask
  task bitop(input logic [7:0] a, input logic w, input logic v);
    @(negedge clk);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = w;
    bit_rd = !w;
    @(negedge clk);
    bit_wr = 1'b0;
    bit_rd = 1'b0;
  endtask
  task pend(input logic [IEP_NSRC-1:0] m);
    @(negedge clk);
    raise <= m;
    @(negedge clk);
    raise <= '0;
  endtask
  task wt(input bit tk);
    int k;
    for (k = 0; k < 40 && (tk ? irq_taken === '0 : core_irq_valid !== 1'b1); k++)
      @(negedge clk);
    chk("wait", 16'h0000, 16'(tk ? irq_taken === '0 : core_irq_valid !== 1'b1));
  endtask
  task reti;
    @(negedge clk);
    core_reti = 1'b1;
    @(negedge clk);
    core_reti = 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    rd(IEP_ADDR_ENABLE);
    chk("enable", 16'h0000, sfr_rdata);
    rd(IEP_ADDR_PRIO);
    chk("prio", 16'h0000, sfr_rdata);
    wr(IEP_ADDR_PRIO, 8'hff);
    bitop(8'hba, 1'b1, 1'b0);
    rd(IEP_ADDR_PRIO);
    chk("prio", 16'h007b, sfr_rdata);
    bitop(8'hb9, 1'b0, 1'b0);
    chk("prio_bit", 16'h0001, bit_rdata);
    bitop(8'h00, 1'b0, 1'b0);
    wr(IEP_ADDR_PRIO, 8'h00);
    rd(8'h00);
    chk("unmapped", 16'h0000, sfr_rdata);
  endtask
  task t_enables;
    int s[7] = '{1, 3, 4, 5, 6, 7, 2};
    for (int i = 0; i < 7; i++) begin
      ack_wait <= 4'(i);
      wr(IEP_ADDR_ENABLE, 8'h80 | (8'h01 << i));
      pend(9'h001 << s[i]);
      wt(0);
      chk("vector", 16'h0003 + 16'(8 * s[i]), core_irq_vector);
      wt(1);
      chk("taken", 16'(9'h001 << s[i]), irq_taken);
      chk("in_service", 16'h0001, in_service);
      reti;
    end
  endtask
  task t_global;
    ack_wait <= 4'h0;
    wr(IEP_ADDR_ENABLE, 8'h7f);
    pend(9'h002);
    repeat (4) @(negedge clk);
    chk("valid", 16'h0000, core_irq_valid);
    wr(IEP_ADDR_ENABLE, 8'h80);
    repeat (3) @(negedge clk);
    chk("valid", 16'h0000, core_irq_valid);
    wr(IEP_ADDR_ENABLE, 8'h81);
    wt(1);
    chk("taken", 16'h0002, irq_taken);
    reti;
  endtask
  task t_order;
    ack_on <= 1'b0;
    wr(IEP_ADDR_ENABLE, 8'hff);
    pend(9'h082);
    wt(0);
    chk("vector", 16'h000b, core_irq_vector);
    bitop(8'hbd, 1'b1, 1'b1);
    @(negedge clk);
    chk("vector", 16'h003b, core_irq_vector);
    chk("high", 16'h0001, core_irq_high);
    ack_on <= 1'b1;
    wt(1);
    chk("in_service", 16'h0002, in_service);
    repeat (3) @(negedge clk);
    chk("valid", 16'h0000, core_irq_valid);
    reti;
    wt(1);
    chk("taken", 16'h0002, irq_taken);
    reti;
  endtask
  task t_preempt;
    wr(IEP_ADDR_PRIO, 8'h10);
    pend(9'h002);
    wt(1);
    ack_on <= 1'b0;
    pend(9'h048);
    wt(0);
    chk("vector", 16'h0033, core_irq_vector);
    chk("high", 16'h0001, core_irq_high);
    ack_on <= 1'b1;
    wt(1);
    chk("in_service", 16'h0003, in_service);
    reti;
    reti;
    wt(1);
    chk("taken", 16'h0008, irq_taken);
    reti;
  endtask
  task t_second;
    rd(IEP_ADDR_SECOND);
    chk("second", 16'h00a0, sfr_rdata);
    wr(IEP_ADDR_SECOND, 8'h0e);
    rd(IEP_ADDR_SECOND);
    chk("second", 16'h0006, sfr_rdata);
    wr(IEP_ADDR_ENABLE, 8'h80);
    rd(IEP_ADDR_ENABLE);
    chk("enable", 16'h0080, sfr_rdata);
    pend(9'h101);
    wt(0);
    chk("vector", 16'h0003, core_irq_vector);
    wt(1);
    chk("taken", 16'h0001, irq_taken);
    reti;
    wt(1);
    chk("taken", 16'h0100, irq_taken);
    reti;
  endtask
  // main sequence, reset held 16 cycles
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_regs;
    t_enables;
    t_global;
    t_order;
    t_preempt;
    t_second;
    finish_test;
  end
  // watchdog, about twenty times the expected run
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end
endmodule // interrupt_enable_priority_tb
